// >>> hw/ccb_defs.svh
`ifndef CCB_DEFS_SVH
`define CCB_DEFS_SVH

// ****************************************
// Command byte layout
// ****************************************
`define CCB_CMD_DIR_BIT 7
`define CCB_CMD_REV_BIT 6
`define CCB_CMD_CLASS_HI 5
`define CCB_CMD_CLASS_LO 4
`define CCB_CMD_CODE_HI 3
`define CCB_CMD_CODE_LO 0
`define CCB_CLASS_STATUS 2'h1
`define CCB_CLASS_EXT 2'h3

// ****************************************
// Extended command codes
// ****************************************
`define CCB_XC_SLEEP 4'h0
`define CCB_XC_WAKE 4'h1
`define CCB_XC_SWAP 4'hd
`define CCB_XC_SRESET 4'he
`define CCB_XC_NOOP 4'hf

// ****************************************
// Register indices (status command code)
// ****************************************
`define CCB_NUM_REGS 9
`define CCB_IDX_GENERAL 4'h0
`define CCB_IDX_IFMT 4'h1
`define CCB_IDX_FILTER 4'h2
`define CCB_IDX_TONE 4'h3
`define CCB_IDX_TROUTE 4'h4
`define CCB_IDX_MIC 4'h5
`define CCB_IDX_EARSPK 4'h6
`define CCB_IDX_LOOP 4'h7
`define CCB_IDX_SERIAL 4'h8

// ****************************************
// Reset values and writable-bit masks
// ****************************************
`define CCB_RST_IFMT 8'hf0
`define CCB_RST_ZERO 8'h00
`define CCB_MASK_ALL 8'hff
`define CCB_MASK_FILTER 8'hf7
`define CCB_MASK_TROUTE 8'hdc
`define CCB_MASK_MIC 8'hfb
`define CCB_MASK_LOOP 8'h7f
`define CCB_MASK_SERIAL 8'h3f

// ****************************************
// Field positions
// ****************************************
`define CCB_G_HF 7
`define CCB_G_AGC_TX 6
`define CCB_G_AGC_RX 5
`define CCB_G_VTX 4
`define CCB_G_SLOT 3
`define CCB_G_PWR 2
`define CCB_G_DUAL 1
`define CCB_G_LAW 0
`define CCB_F_TXG 7
`define CCB_F_RXG 6
`define CCB_F_SIDE 5
`define CCB_F_TXEQ 4
`define CCB_F_RXEQ 2
`define CCB_F_RXHP 1
`define CCB_F_TXHP 0
`define CCB_T_SRC 7
`define CCB_T_SECOND 6
`define CCB_T_FILT 5
`define CCB_T_CAD 4
`define CCB_T_BEAT 3
`define CCB_T_THREE 2
`define CCB_T_STOP 1
`define CCB_T_SQUARE 0
`define CCB_R_PIEZO 7
`define CCB_R_SPK 6
`define CCB_R_RXT 4
`define CCB_R_DIAL 3
`define CCB_R_TXT 2
`define CCB_M_VREF 3
`define CCB_E_LIM 4
`define CCB_L_PZST 6
`define CCB_S_PP1 5
`define CCB_S_PP0 4
`define CCB_S_DBL 3

// ****************************************
// Level codes and loop limits
// ****************************************
`define CCB_SPK_OFF 4'h0
`define CCB_SPK_CAP 4'h8
`define CCB_LOOP_MAX 3'h4
`define CCB_LOOP_NONE 3'h0
`define CCB_PINDIR_ALL_IN 4'hf

`endif

// >>> hw/ccb_pkg.sv
package ccb_pkg;

  typedef enum logic {
    CCB_ST_CMD,
    CCB_ST_DATA
  } ccb_state_t;

  typedef struct packed {
    ccb_state_t state;
    logic [3:0] wr_idx;
    logic [8:0][7:0] regs;
    logic swap;
    logic rev;
    logic resp_valid;
    logic [7:0] resp_data;
    logic strap_meta;
    logic strap_sync;
  } ccb_regs_t;

endpackage : ccb_pkg

// >>> hw/ccb_config_bank.sv
// Function
// - Top class bits 11 select extended commands
// - Command top bit zero writes, one reads
// - Channel swap command toggles line exchange
// - Code 1110 soft reset, 1111 no-op
// - Power bit zero is standby; keeps state
// - Automatic gain only while handsfree enabled
// - Voice transmit sends idle when powered down
// - Slot bit picks frame channel 0/1, terminal mode only
// - Dual-device bit changes channel-select meaning
// - Companding: zero A-law, one mu-law
// - Signaling pin direction, terminal mode only
// - Voice route mode field selects routing
// - Gains and equalizers zero default, one coefficients
// - Highpass off bits remove hum filters
// - Tone runs on source or cadence enable
// - Second tone only without dial transmit
// - Three-tone ring and automatic stop
// - Trapezoid only without speaker or piezo ring
// - Ringing and tone direction routing enables
// - Speech caps louder speaker level at -9.5dB
// - Microphone input select, fourth code unused
// - Piezo pins show handsfree status
// - Analog and digital loop select fields
// - Serial push-pull, double clock, master rate
`timescale 1ns/1ps
`include "ccb_defs.svh"
`default_nettype none

module ccb_config_bank (
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic cmd_valid, // Byte from controller present
  input wire logic cmd_first, // Byte is a command byte
  input wire logic [7:0] cmd_data, // Command or data byte
  input wire logic addr_strap_pin, // Chip address strap pin
  input wire logic terminal_mode, // Bus runs in terminal mode
  input wire logic speech_tx_detect, // Transmit speech detected
  input wire logic hf_idle, // Handsfree idle state
  input wire logic hf_tx_active, // Handsfree transmit active
  output logic resp_valid, // Read data pulse
  output logic [7:0] resp_data, // Read data byte
  output logic chan_second, // Command data uses second channel
  output logic line_swap, // Downstream/upstream lines exchanged
  output logic power_active, // Normal operation, else standby
  output logic handsfree_enable, // Speakerphone support on
  output logic agc_tx_on, // Transmit automatic gain active
  output logic agc_rx_on, // Receive automatic gain active
  output logic voice_tx_send, // Send transmit voice samples
  output logic voice_tx_idle, // Send idle code
  output logic bearer_in_ch1, // Bearer voice in frame channel 1
  output logic mu_law_sel, // Mu-law coding, else A-law
  output logic [3:0] signal_pin_input, // Signaling pin is input
  output logic [3:0] voice_route_mode, // Voice routing mode
  output logic tx_gain_load, // Transmit gain from coefficients
  output logic rx_gain_load, // Receive gain from coefficients
  output logic sidetone_load, // Sidetone from coefficients
  output logic tx_eq_enable, // Transmit equalizer in path
  output logic rx_eq_enable, // Receive equalizer in path
  output logic rx_highpass_on, // Receive hum filter active
  output logic tx_highpass_on, // Transmit hum filter active
  output logic tone_gen_run, // Tone generator running
  output logic cadence_run, // Cadence generator running
  output logic tone_filter_on, // Tone filter in path
  output logic second_tone_on, // Second trapezoid added
  output logic beat_ring_on, // Beat ring generator on
  output logic three_tone_ring, // Three-tone ring, else two
  output logic auto_stop_on, // Ring stops after sequence
  output logic square_wave_on, // Square tone, else trapezoid
  output logic piezo_ring_out, // Ringing to piezo pins
  output logic speaker_ring_out, // Ringing to speaker pins
  output logic rx_tone_on, // Tone in receive direction
  output logic tx_tone_on, // Tone in transmit direction
  output logic dial_tx_on, // Dial tone in transmit direction
  output logic [3:0] mic_amp_mode, // Microphone amplifier setting
  output logic vref_force_on, // Reference held on
  output logic [1:0] mic_input_select, // Microphone input choice
  output logic mic_input_valid, // Input choice is a used code
  output logic [2:0] earpiece_mode, // Earpiece amplifier setting
  output logic [3:0] speaker_amp, // Effective speaker level
  output logic piezo_status_mode, // Piezo pins show status
  output logic piezo_pin1, // Piezo pin 1 status level
  output logic piezo_pin2, // Piezo pin 2 status level
  output logic [2:0] analog_loop_select, // Analog loop choice
  output logic [2:0] digital_loop_select, // Digital loop choice
  output logic uplink_pushpull, // Uplink pin push-pull
  output logic serial_out_pushpull, // Serial out pin push-pull
  output logic bit_clock_double, // Double bit clock rate
  output logic [2:0] master_clock_rate_sel // Master clock rate code
);

  // ****************************************
  // Register bank constants
  // ****************************************
  localparam logic [8:0][7:0] RST_VALS = {
    `CCB_RST_ZERO, `CCB_RST_ZERO, `CCB_RST_ZERO, `CCB_RST_ZERO, `CCB_RST_ZERO,
    `CCB_RST_ZERO, `CCB_RST_ZERO, `CCB_RST_IFMT, `CCB_RST_ZERO
  };
  localparam logic [8:0][7:0] WR_MASKS = {
    `CCB_MASK_SERIAL, `CCB_MASK_LOOP, `CCB_MASK_ALL, `CCB_MASK_MIC, `CCB_MASK_TROUTE,
    `CCB_MASK_ALL, `CCB_MASK_FILTER, `CCB_MASK_ALL, `CCB_MASK_ALL
  };

  ccb_pkg::ccb_regs_t cur_ff;
  ccb_pkg::ccb_regs_t nxt_cur;

  logic [1:0] cmd_class;
  logic [3:0] cmd_code;
  logic cmd_read;
  logic idx_ok;

  assign cmd_class = cmd_data[`CCB_CMD_CLASS_HI:`CCB_CMD_CLASS_LO];
  assign cmd_code = cmd_data[`CCB_CMD_CODE_HI:`CCB_CMD_CODE_LO];
  assign cmd_read = cmd_data[`CCB_CMD_DIR_BIT];
  assign idx_ok = (cmd_code < 4'(`CCB_NUM_REGS));

  // ****************************************
  // Command decode and register update
  // ****************************************
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.resp_valid = 1'b0;
    // Strap pin crosses in from outside; second stage alone is used
    nxt_cur.strap_meta = addr_strap_pin;
    nxt_cur.strap_sync = cur_ff.strap_meta;
    if (cmd_valid && cmd_first) begin
      // A fresh command byte always aborts a pending data phase
      nxt_cur.state = ccb_pkg::CCB_ST_CMD;
      if (!cmd_read) begin
        nxt_cur.rev = cmd_data[`CCB_CMD_REV_BIT];
      end
      if (cmd_class == `CCB_CLASS_EXT) begin
        if (!cmd_read) begin
          case (cmd_code)
            `CCB_XC_SLEEP: begin
              nxt_cur.regs[`CCB_IDX_GENERAL][`CCB_G_PWR] = 1'b0;
            end
            `CCB_XC_WAKE: begin
              nxt_cur.regs[`CCB_IDX_GENERAL][`CCB_G_PWR] = 1'b1;
            end
            `CCB_XC_SWAP: begin
              nxt_cur.swap = ~cur_ff.swap;
            end
            `CCB_XC_SRESET: begin
              nxt_cur.regs = RST_VALS;
              nxt_cur.swap = 1'b0;
              nxt_cur.rev = 1'b0;
            end
            default: begin
              // No-op and undefined codes change nothing beyond the reverse bit loaded above
            end
          endcase
        end
      end else if (cmd_class == `CCB_CLASS_STATUS && idx_ok) begin
        if (cmd_read) begin
          nxt_cur.resp_valid = 1'b1;
          nxt_cur.resp_data = cur_ff.regs[cmd_code[3:0]];
        end else begin
          nxt_cur.state = ccb_pkg::CCB_ST_DATA;
          nxt_cur.wr_idx = cmd_code;
        end
      end
    end else if (cmd_valid) begin
      case (cur_ff.state)
        ccb_pkg::CCB_ST_DATA: begin
          // Fixed-zero positions are masked off on the way
          nxt_cur.regs[cur_ff.wr_idx] = cmd_data & WR_MASKS[cur_ff.wr_idx];
          nxt_cur.state = ccb_pkg::CCB_ST_CMD;
        end
        ccb_pkg::CCB_ST_CMD: begin
          // Stray data bytes without a command are dropped
        end
        default: begin
          nxt_cur.state = ccb_pkg::CCB_ST_CMD;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_ff.state <= ccb_pkg::CCB_ST_CMD;
      cur_ff.wr_idx <= 4'h0;
      cur_ff.regs <= RST_VALS;
      cur_ff.swap <= 1'b0;
      cur_ff.rev <= 1'b0;
      cur_ff.resp_valid <= 1'b0;
      cur_ff.resp_data <= 8'h00;
      cur_ff.strap_meta <= 1'b0;
      cur_ff.strap_sync <= 1'b0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ****************************************
  // Register field views
  // ****************************************
  logic [7:0] gen_r;
  logic [7:0] ifmt_r;
  logic [7:0] filt_r;
  logic [7:0] tone_r;
  logic [7:0] trt_r;
  logic [7:0] mic_r;
  logic [7:0] esp_r;
  logic [7:0] loop_r;
  logic [7:0] ser_r;

  assign gen_r = cur_ff.regs[`CCB_IDX_GENERAL];
  assign ifmt_r = cur_ff.regs[`CCB_IDX_IFMT];
  assign filt_r = cur_ff.regs[`CCB_IDX_FILTER];
  assign tone_r = cur_ff.regs[`CCB_IDX_TONE];
  assign trt_r = cur_ff.regs[`CCB_IDX_TROUTE];
  assign mic_r = cur_ff.regs[`CCB_IDX_MIC];
  assign esp_r = cur_ff.regs[`CCB_IDX_EARSPK];
  assign loop_r = cur_ff.regs[`CCB_IDX_LOOP];
  assign ser_r = cur_ff.regs[`CCB_IDX_SERIAL];

  assign resp_valid = cur_ff.resp_valid;
  assign resp_data = cur_ff.resp_data;
  assign line_swap = cur_ff.swap;

  // ****************************************
  // General and interface format
  // ****************************************
  // While the dual-device bit is clear the strap reverses channel choice
  assign chan_second = cur_ff.rev ^ (~gen_r[`CCB_G_DUAL] & cur_ff.strap_sync);
  assign power_active = gen_r[`CCB_G_PWR];
  assign handsfree_enable = gen_r[`CCB_G_HF];
  assign agc_tx_on = gen_r[`CCB_G_AGC_TX] & gen_r[`CCB_G_HF];
  assign agc_rx_on = gen_r[`CCB_G_AGC_RX] & gen_r[`CCB_G_HF];
  assign voice_tx_send = gen_r[`CCB_G_VTX] & gen_r[`CCB_G_PWR];
  assign voice_tx_idle = gen_r[`CCB_G_VTX] & ~gen_r[`CCB_G_PWR];
  assign bearer_in_ch1 = terminal_mode & gen_r[`CCB_G_SLOT];
  assign mu_law_sel = gen_r[`CCB_G_LAW];
  // Outside terminal mode the signaling pins stay inputs
  assign signal_pin_input = terminal_mode ? ifmt_r[7:4] : `CCB_PINDIR_ALL_IN;
  assign voice_route_mode = ifmt_r[3:0];

  // ****************************************
  // Filters
  // ****************************************
  assign tx_gain_load = filt_r[`CCB_F_TXG];
  assign rx_gain_load = filt_r[`CCB_F_RXG];
  assign sidetone_load = filt_r[`CCB_F_SIDE];
  assign tx_eq_enable = filt_r[`CCB_F_TXEQ];
  assign rx_eq_enable = filt_r[`CCB_F_RXEQ];
  assign rx_highpass_on = ~filt_r[`CCB_F_RXHP];
  assign tx_highpass_on = ~filt_r[`CCB_F_TXHP];

  // ****************************************
  // Tone generation and routing
  // ****************************************
  assign cadence_run = tone_r[`CCB_T_CAD];
  assign tone_gen_run = tone_r[`CCB_T_SRC] | tone_r[`CCB_T_CAD];
  assign tone_filter_on = tone_r[`CCB_T_FILT];
  assign second_tone_on = tone_r[`CCB_T_SECOND] & ~trt_r[`CCB_R_DIAL];
  assign beat_ring_on = tone_r[`CCB_T_BEAT];
  assign three_tone_ring = tone_r[`CCB_T_BEAT] & tone_r[`CCB_T_THREE] & ~trt_r[`CCB_R_DIAL];
  assign auto_stop_on = tone_r[`CCB_T_STOP];
  // Piezo and speaker ringing can only carry a square wave
  assign square_wave_on = tone_r[`CCB_T_SQUARE] | trt_r[`CCB_R_PIEZO] | trt_r[`CCB_R_SPK];
  assign piezo_ring_out = trt_r[`CCB_R_PIEZO];
  assign speaker_ring_out = trt_r[`CCB_R_SPK];
  assign rx_tone_on = trt_r[`CCB_R_RXT];
  assign tx_tone_on = trt_r[`CCB_R_TXT];
  assign dial_tx_on = trt_r[`CCB_R_DIAL];

  // ****************************************
  // Microphone, earpiece and speaker
  // ****************************************
  assign mic_amp_mode = mic_r[7:4];
  assign vref_force_on = mic_r[`CCB_M_VREF];
  assign mic_input_select = mic_r[1:0];
  assign mic_input_valid = ~(mic_r[1] & mic_r[0]);
  assign earpiece_mode = esp_r[7:5];

  logic spk_louder;
  logic spk_cap;

  // Louder than the cap means any active code below it; the off code 0 is excluded
  assign spk_louder = (esp_r[3:0] != `CCB_SPK_OFF) && (esp_r[3:0] < `CCB_SPK_CAP);
  assign spk_cap = esp_r[`CCB_E_LIM] & gen_r[`CCB_G_HF] & speech_tx_detect & spk_louder;
  assign speaker_amp = spk_cap ? `CCB_SPK_CAP : esp_r[3:0];

  assign piezo_status_mode = loop_r[`CCB_L_PZST] & trt_r[`CCB_R_PIEZO];
  assign piezo_pin1 = piezo_status_mode & hf_idle;
  assign piezo_pin2 = piezo_status_mode & hf_tx_active;

  // ****************************************
  // Loops and serial port
  // ****************************************
  // Codes above the last defined loop fall back to no loop
  assign analog_loop_select = (loop_r[5:3] > `CCB_LOOP_MAX) ? `CCB_LOOP_NONE : loop_r[5:3];
  assign digital_loop_select = (loop_r[2:0] > `CCB_LOOP_MAX) ? `CCB_LOOP_NONE : loop_r[2:0];
  assign uplink_pushpull = ser_r[`CCB_S_PP0];
  assign serial_out_pushpull = ser_r[`CCB_S_PP1];
  assign bit_clock_double = ser_r[`CCB_S_DBL];
  assign master_clock_rate_sel = ser_r[2:0];

endmodule : ccb_config_bank

`default_nettype wire

// >>> verif/ccb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Controller byte driver
// ****************
module ccb_host_model (
  input wire logic sys_clk, // System clock
  output logic cmd_valid, // Byte present
  output logic cmd_first, // Command byte flag
  output logic [7:0] cmd_data // Byte value
);
  initial begin
    cmd_valid = 1'b0;
    cmd_first = 1'b0;
    cmd_data = 8'h00;
  end
  // Callers keep command before its data byte
  task send(input logic f, input logic [7:0] d);
    @(negedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_first <= f;
    cmd_data <= d;
  endtask : send
  // Released bus shows inverted data so a stale byte is never reused
  task idle();
    cmd_valid <= 1'b0;
    cmd_first <= 1'b0;
    cmd_data <= ~cmd_data;
  endtask : idle
endmodule : ccb_host_model
`default_nettype wire

// >>> verif/ccb_config_bank_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Port checker
// ****************
module ccb_config_bank_chk (
  input wire logic sys_clk, // Clock
  input wire logic arst_n, // Reset, active low
  input wire logic cmd_valid, // Byte present
  input wire logic cmd_first, // Command byte
  input wire logic [7:0] cmd_data, // Byte value
  input wire logic terminal_mode, // Terminal mode
  input wire logic resp_valid, // Read pulse
  input wire logic line_swap, // Lines exchanged
  input wire logic power_active, // Powered up
  input wire logic handsfree_enable, // Speakerphone on
  input wire logic agc_tx_on, // Tx gain control
  input wire logic voice_tx_send, // Tx voice
  input wire logic voice_tx_idle, // Tx idle code
  input wire logic [3:0] signal_pin_input, // Pin directions
  input wire logic tone_gen_run, // Tone running
  input wire logic cadence_run, // Cadence running
  input wire logic second_tone_on, // Second tone
  input wire logic dial_tx_on, // Dial tone tx
  input wire logic square_wave_on, // Square shape
  input wire logic piezo_ring_out, // Piezo ring
  input wire logic speaker_ring_out // Speaker ring
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);
  logic cmd;
  logic rd_cmd;
  assign cmd = cmd_valid && cmd_first;
  assign rd_cmd = cmd && cmd_data[7] && cmd_data[5:4] == 2'b01 && cmd_data[3:0] < 4'h9;
  a_swap_toggle: assert property (
    cmd && cmd_data == 8'h3d |=> line_swap != $past(line_swap)) else $error("swap not toggled");
  a_sleep_clear: assert property (
    cmd && cmd_data == 8'h30 |=> !power_active) else $error("sleep ignored");
  a_wake_set: assert property (
    cmd && cmd_data == 8'h31 |=> power_active) else $error("wake ignored");
  a_soft_reset: assert property (
    cmd && cmd_data == 8'h3e |=> !line_swap && !power_active && signal_pin_input == 4'hf)
    else $error("soft reset incomplete");
  a_undef_ignored: assert property (
    cmd && cmd_data == 8'h32 |=> $stable(line_swap) && $stable(power_active))
    else $error("undefined code changed state");
  a_read_pulse: assert property (
    rd_cmd |=> resp_valid) else $error("read gave no response");
  a_resp_cause: assert property (
    resp_valid |-> $past(rd_cmd)) else $error("response without read");
  a_agc_gate: assert property (
    agc_tx_on |-> handsfree_enable) else $error("gain control without handsfree");
  a_idle_code: assert property (
    voice_tx_idle |-> !power_active && !voice_tx_send) else $error("idle code wrong");
  a_pin_dir: assert property (
    !terminal_mode |-> signal_pin_input == 4'hf) else $error("pin direction outside mode");
  a_cadence_tone: assert property (
    cadence_run |-> tone_gen_run) else $error("cadence without tone");
  a_second_dial: assert property (
    second_tone_on |-> !dial_tx_on) else $error("second tone with dial");
  a_square_ring: assert property (
    piezo_ring_out || speaker_ring_out |-> square_wave_on) else $error("ring not square");
  c_swap: cover property (cmd && cmd_data == 8'h3d);
  c_read: cover property (resp_valid);
  c_agc: cover property (agc_tx_on);
endmodule : ccb_config_bank_chk
bind ccb_config_bank ccb_config_bank_chk chk_u (.sys_clk, .arst_n, .cmd_valid, .cmd_first,
  .cmd_data, .terminal_mode, .resp_valid, .line_swap, .power_active, .handsfree_enable,
  .agc_tx_on, .voice_tx_send, .voice_tx_idle, .signal_pin_input, .tone_gen_run, .cadence_run,
  .second_tone_on, .dial_tx_on, .square_wave_on, .piezo_ring_out, .speaker_ring_out);
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Bench top
// ****************
module testbench;
  logic sys_clk, arst_n, cmd_valid, cmd_first, addr_strap_pin, terminal_mode;
  logic speech_tx_detect, hf_idle, hf_tx_active, resp_valid, chan_second, line_swap;
  logic power_active, agc_tx_on, agc_rx_on, voice_tx_idle, bearer_in_ch1, mu_law_sel;
  logic sidetone_load, rx_highpass_on, tone_gen_run, second_tone_on, three_tone_ring;
  logic square_wave_on, rx_tone_on, mic_input_valid, piezo_pin2;
  logic handsfree_enable, voice_tx_send, tx_gain_load, rx_gain_load, tx_eq_enable, rx_eq_enable;
  logic tx_highpass_on, cadence_run, tone_filter_on, beat_ring_on, auto_stop_on, piezo_ring_out;
  logic speaker_ring_out, tx_tone_on, dial_tx_on, vref_force_on, piezo_status_mode, piezo_pin1;
  logic uplink_pushpull, serial_out_pushpull, bit_clock_double;
  logic [7:0] cmd_data, resp_data;
  logic [3:0] signal_pin_input, voice_route_mode, speaker_amp, mic_amp_mode;
  logic [2:0] analog_loop_select, digital_loop_select, master_clock_rate_sel, earpiece_mode;
  logic [1:0] mic_input_select;
  logic [7:0] m [9];
  logic [7:0] msk [9] = '{8'hff, 8'hff, 8'hf7, 8'hff, 8'hdc, 8'hfb, 8'hff, 8'h7f, 8'h3f};
  logic [7:0] bad [5] = '{8'h05, 8'h25, 8'h19, 8'hb0, 8'hbf};
  logic msw, mrev;
  int err_total = 0;
  int n_compared = 0;
  ccb_host_model host_u (.sys_clk, .cmd_valid, .cmd_first, .cmd_data);
  ccb_config_bank dut_u (.sys_clk, .arst_n, .cmd_valid, .cmd_first, .cmd_data, .addr_strap_pin,
    .terminal_mode, .speech_tx_detect, .hf_idle, .hf_tx_active, .resp_valid, .resp_data,
    .chan_second, .line_swap, .power_active, .handsfree_enable, .agc_tx_on, .agc_rx_on,
    .voice_tx_send, .voice_tx_idle, .bearer_in_ch1, .mu_law_sel, .signal_pin_input,
    .voice_route_mode, .tx_gain_load, .rx_gain_load, .sidetone_load, .tx_eq_enable,
    .rx_eq_enable, .rx_highpass_on, .tx_highpass_on, .tone_gen_run, .cadence_run,
    .tone_filter_on, .second_tone_on, .beat_ring_on, .three_tone_ring, .auto_stop_on,
    .square_wave_on, .piezo_ring_out, .speaker_ring_out, .rx_tone_on, .tx_tone_on,
    .dial_tx_on, .mic_amp_mode, .vref_force_on, .mic_input_select, .mic_input_valid,
    .earpiece_mode, .speaker_amp, .piezo_status_mode, .piezo_pin1, .piezo_pin2,
    .analog_loop_select, .digital_loop_select, .uplink_pushpull, .serial_out_pushpull,
    .bit_clock_double, .master_clock_rate_sel);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task summarize();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  task cmp(input string s, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : cmp
  task mreset();
    foreach (m[i]) m[i] = (i == 1) ? 8'hf0 : 8'h00;
    msw = 1'b0;
    mrev = 1'b0;
  endtask : mreset
  task wr(input logic [3:0] i, input logic [7:0] v, input logic rv);
    host_u.send(1'b1, {1'b0, rv, 2'b01, i});
    host_u.send(1'b0, v);
    @(negedge sys_clk);
    host_u.idle();
    mrev = rv;
    if (i < 9) m[i] = v & msk[i];
  endtask : wr
  task rd(input logic [3:0] i);
    host_u.send(1'b1, {4'h9, i});
    @(negedge sys_clk);
    host_u.idle();
    cmp("resp_valid", 8'h01, {7'h0, resp_valid});
    cmp("resp_data", m[i], resp_data);
  endtask : rd
  task ext(input logic [3:0] c);
    host_u.send(1'b1, {4'h3, c});
    @(negedge sys_clk);
    host_u.idle();
    mrev = 1'b0;
    case (c)
      4'h0: m[0][2] = 1'b0;
      4'h1: m[0][2] = 1'b1;
      4'hd: msw = ~msw;
      4'he: mreset();
      default: ;
    endcase
  endtask : ext
  task chk();
    logic [7:0] g, t, r, e, l;
    g = m[0];
    t = m[3];
    r = m[4];
    e = m[6];
    l = m[7];
    cmp("power_active", g[2], power_active);
    cmp("line_swap", msw, line_swap);
    cmp("agc_tx_on", g[6] & g[7], agc_tx_on);
    cmp("agc_rx_on", g[5] & g[7], agc_rx_on);
    cmp("voice_tx_idle", g[4] & ~g[2], voice_tx_idle);
    cmp("bearer_in_ch1", terminal_mode & g[3], bearer_in_ch1);
    cmp("chan_second", mrev ^ (~g[1] & addr_strap_pin), chan_second);
    cmp("mu_law_sel", g[0], mu_law_sel);
    cmp("signal_pin_input", terminal_mode ? m[1][7:4] : 4'hf, signal_pin_input);
    cmp("voice_route_mode", m[1][3:0], voice_route_mode);
    cmp("sidetone_load", m[2][5], sidetone_load);
    cmp("rx_highpass_on", !m[2][1], rx_highpass_on);
    cmp("tone_gen_run", t[7] | t[4], tone_gen_run);
    cmp("second_tone_on", t[6] & ~r[3], second_tone_on);
    cmp("three_tone_ring", t[3] & t[2] & ~r[3], three_tone_ring);
    cmp("square_wave_on", t[0] | r[7] | r[6], square_wave_on);
    cmp("rx_tone_on", r[4], rx_tone_on);
    cmp("speaker_amp", (e[4] & g[7] & speech_tx_detect && e[3:0] > 0 && e[3:0] < 8)
      ? 4'h8 : e[3:0], speaker_amp);
    cmp("mic_input_valid", ~&m[5][1:0], mic_input_valid);
    cmp("piezo_pin2", l[6] & r[7] & hf_tx_active, piezo_pin2);
    cmp("analog_loop", l[5:3] > 4 ? 3'h0 : l[5:3], analog_loop_select);
    cmp("digital_loop", l[2:0] > 4 ? 3'h0 : l[2:0], digital_loop_select);
    cmp("master_clock_rate_sel", m[8][2:0], master_clock_rate_sel);
    cmp("hf_vtx", {g[7], g[4] & g[2]}, {handsfree_enable, voice_tx_send});
    cmp("filter", {m[2][7:6], m[2][4], m[2][2], !m[2][0]},
      {tx_gain_load, rx_gain_load, tx_eq_enable, rx_eq_enable, tx_highpass_on});
    cmp("tone", {t[5], t[4], t[3], t[1], r[7:6], r[3:2]}, {tone_filter_on, cadence_run,
      beat_ring_on, auto_stop_on, piezo_ring_out, speaker_ring_out, dial_tx_on,
      tx_tone_on});
    cmp("mic", {m[5][7:3], m[5][1:0]}, {mic_amp_mode, vref_force_on, mic_input_select});
    cmp("earpiece_mode", e[7:5], earpiece_mode);
    cmp("piezo", {2{l[6] & r[7]}} & {1'b1, hf_idle}, {piezo_status_mode, piezo_pin1});
    cmp("serial", m[8][5:3], {serial_out_pushpull, uplink_pushpull, bit_clock_double});
  endtask : chk
  // Hang guard; the run itself is a few hundred cycles
  initial begin
    #500us;
    err_total++;
    summarize();
  end
  initial begin
    arst_n = 1'b0;
    {terminal_mode, speech_tx_detect, hf_idle, hf_tx_active, addr_strap_pin} = 5'h00;
    mreset();
    void'($urandom(96));
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1'b1;
    for (int i = 0; i < 9; i++) rd(4'(i));
    chk();
    $display("test reset_values done");
    repeat (60) begin
      {terminal_mode, speech_tx_detect, hf_idle, hf_tx_active, addr_strap_pin} = 5'($urandom);
      wr(4'($urandom % 9), 8'($urandom), 1'($urandom));
      repeat (3) @(negedge sys_clk);
      chk();
    end
    for (int i = 0; i < 9; i++) rd(4'(i));
    $display("test random_config done");
    wr(4'h0, 8'h84, 1'b1);
    host_u.send(1'b1, 8'h10);
    host_u.send(1'b1, 8'h90);
    @(negedge sys_clk);
    host_u.idle();
    mrev = 1'b0;
    cmp("resp_data", m[0], resp_data);
    foreach (bad[k]) begin
      host_u.send(1'b1, bad[k]);
      host_u.send(1'b0, 8'h5a);
      @(negedge sys_clk);
      host_u.idle();
    end
    repeat (3) @(negedge sys_clk);
    chk();
    $display("test abort_refused done");
    wr(4'h0, 8'hff, 1'b0);
    for (int c = 0; c < 16; c++) begin
      ext(4'(c));
      repeat (3) @(negedge sys_clk);
      chk();
    end
    for (int i = 0; i < 9; i++) rd(4'(i));
    $display("test extended_codes done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
